// File: spicsf_map.svh
// Register offsets, field positions and reset values of the serial port control block
`ifndef SPICSF_MAP_SVH
`define SPICSF_MAP_SVH

// Register offsets on the plain register port
`define SPICSF_ADDR_W          4
`define SPICSF_CS_ADDR         4'h0
`define SPICSF_MASK_ADDR       4'h1
`define SPICSF_DATA_ADDR       4'h2
`define SPICSF_EVT_ADDR        4'h3

// Control and status field positions
`define SPICSF_DONE_BIT        7
`define SPICSF_WRITE_COLLISION_FLAG_BIT        6
`define SPICSF_MODE_FAULT_FLAG_BIT        5
`define SPICSF_OVR_BIT         4
`define SPICSF_MODE_HI         3
`define SPICSF_MODE_LO         2
`define SPICSF_TRANSMIT_BUFFER_EMPTY_BIT       1
`define SPICSF_EN_BIT          0

// Control and status reset value: mode 01, transmit buffer empty
`define SPICSF_CS_RESET        8'h06

// Event status and mask field positions
`define SPICSF_EV_DONE         3
`define SPICSF_EV_WRITE_COLLISION_FLAG         2
`define SPICSF_EV_MODE_FAULT_FLAG         1
`define SPICSF_EV_OVR          0
`define SPICSF_EV_W            4
`define SPICSF_MASK_RESET      4'h0

`endif

// File: spicsf_pkg.sv
// Types shared by the serial port control block
package spicsf_pkg;

   // Select line modes held in control bits 3:2
   typedef enum logic [1:0] {
      SPICSF_THREE_WIRE  = 2'b00,
      SPICSF_FOUR_WIRE   = 2'b01,
      SPICSF_SINGLE_LOW  = 2'b10,
      SPICSF_SINGLE_HIGH = 2'b11
   } spicsf_mode_t;

endpackage

// File: spicsf_sync_if.sv
// Carrier between a pin synchroniser and the control block
`timescale 1ns/1ps
interface spicsf_sync_if;
   logic pin_raw;     // Raw pin level, outside the clock domain
   logic level;       // Filtered level in the clock domain
   logic rise;        // One-cycle pulse on a filtered rising change

   modport sync (input pin_raw, output level, output rise);
   modport user (output pin_raw, input level, input rise);
endinterface

// File: spicsf_pin_sync.sv
// Three-flop pin synchroniser that accepts a change once two stages agree
`timescale 1ns/1ps
module spicsf_pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input  wire logic  clk,
   input  wire logic  rst_n,
   spicsf_sync_if.sync port
);

   logic meta_r;      // First stage, read only by the second
   logic stage2_r;    // Second stage
   logic stage3_r;    // Third stage
   logic level_r;     // Accepted level
   logic rise_r;      // Rising change pulse
   wire  agree;       // Second and third stages match
   wire  level_nxt;   // Accepted level for the next cycle

   assign agree     = (stage2_r == stage3_r);
   assign level_nxt = agree ? stage3_r : level_r;

   // Shift chain and accepted level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r   <= RESET_LEVEL;
         stage2_r <= RESET_LEVEL;
         stage3_r <= RESET_LEVEL;
         level_r  <= RESET_LEVEL;
         rise_r   <= 1'b0;
      end else begin
         meta_r   <= port.pin_raw;
         stage2_r <= meta_r;
         stage3_r <= stage2_r;
         level_r  <= level_nxt;
         rise_r   <= level_nxt & ~level_r;
      end
   end

   assign port.level = level_r;
   assign port.rise  = rise_r;

endmodule

// File: spicsf_top.sv
// Serial port control, status flags, select line mode and interrupt logic
//
// Functional notes
// - Transfer done sets sticky flag and interrupt
// - Data write during transfer sets collision flag
// - Select low, master, mode 01 sets fault
// - Slave overrun when last bit meets full buffer
// - Every error flag set requests interrupt
// - Error flags clear only by software zero
// - Mode 00 leaves select pin unconnected
// - Mode 01 treats select as input
// - Mode 1x drives select from low bit
// - Data write clears transmit buffer empty
// - Buffer move to shifter sets empty
`timescale 1ns/1ps
`include "spicsf_map.svh"
module spicsf_top (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [`SPICSF_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [7:0]                reg_rdata,
   output logic                           irq,
   input  wire logic                      master_mode_enable,
   input  wire logic                      xfer_busy,
   input  wire logic                      xfer_done,
   input  wire logic                      last_bit_in,
   input  wire logic                      rx_buf_full,
   input  wire logic                      tx_buf_to_shifter,
   output logic                           tx_write,
   output logic      [7:0]                tx_data,
   output logic                           port_enable,
   input  wire logic                      slave_select_line_in,
   output logic                           slave_select_line_out,
   output logic                           slave_select_line_oe,
   output logic                           slave_selected,
   input  wire logic                      sck_in,
   output logic                           sck_rise
);

   // Register state
   logic [7:0]              cs_r;        // Control and status register
   logic [7:0]              cs_nxt;      // Its next value
   logic [`SPICSF_EV_W-1:0] evt_r;       // Sticky event status, read clears
   logic [`SPICSF_EV_W-1:0] evt_nxt;     // Its next value
   logic [`SPICSF_EV_W-1:0] mask_r;      // Interrupt mask
   logic [7:0]              rdata_r;     // Read data, one cycle after strobe
   logic [7:0]              rdata_nxt;   // Its next value
   logic                    irq_r;       // Interrupt output flop
   logic                    tx_write_r;  // Accepted data write pulse
   logic [7:0]              tx_data_r;   // Accepted data byte
   logic                    ss_out_r;    // Select output level
   logic                    ss_oe_r;     // Select output enable
   logic                    ss_sel_r;    // Slave selected indication
   logic                    sck_rise_r;  // Sampled link clock rising edge

   spicsf_sync_if nss_if ();             // Select pin synchroniser carrier
   spicsf_sync_if sck_if ();             // Link clock synchroniser carrier

   assign nss_if.pin_raw = slave_select_line_in;
   assign sck_if.pin_raw = sck_in;

   // Select pin synchroniser, idles high
   spicsf_pin_sync #(.RESET_LEVEL(1'b1)) u_nss_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .port  (nss_if)
   );

   // Link clock synchroniser, idles low
   spicsf_pin_sync #(.RESET_LEVEL(1'b0)) u_sck_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .port  (sck_if)
   );

   // Field decode
   wire                     en_w;        // Port enable bit
   wire spicsf_pkg::spicsf_mode_t mode_w; // Select line mode
   wire                     mode_four;   // Mode 01
   wire                     mode_single; // Mode 1x
   wire                     wr_cs;       // Write to control and status
   wire                     wr_mask;     // Write to mask
   wire                     wr_data;     // Write to data register
   wire                     rd_evt;      // Read of event status
   wire                     ev_done;     // Transfer finished
   wire                     ev_write_collision_flag;     // Write collision
   wire                     ev_mode_fault_flag;     // Mode fault
   wire                     ev_ovr;      // Receive overrun
   wire                     data_ok;     // Data write accepted
   wire [`SPICSF_EV_W-1:0]  ev_vec;      // All events

   assign en_w        = cs_r[`SPICSF_EN_BIT];
   assign mode_w      = spicsf_pkg::spicsf_mode_t'(cs_r[`SPICSF_MODE_HI:`SPICSF_MODE_LO]);
   assign mode_four   = (mode_w == spicsf_pkg::SPICSF_FOUR_WIRE);
   assign mode_single = cs_r[`SPICSF_MODE_HI];
   assign wr_cs       = reg_wr && (reg_addr == `SPICSF_CS_ADDR);
   assign wr_mask     = reg_wr && (reg_addr == `SPICSF_MASK_ADDR);
   assign wr_data     = reg_wr && (reg_addr == `SPICSF_DATA_ADDR) && en_w;
   assign rd_evt      = reg_rd && (reg_addr == `SPICSF_EVT_ADDR);

   // Event sources, all gated by the port enable
   assign ev_done = en_w && xfer_done;
   assign ev_write_collision_flag = wr_data && xfer_busy;
   assign ev_mode_fault_flag = en_w && master_mode_enable && mode_four
                    && !nss_if.level;
   assign ev_ovr  = en_w && !master_mode_enable && last_bit_in
                    && rx_buf_full;
   assign data_ok = wr_data && !xfer_busy;
   assign ev_vec  = {ev_done, ev_write_collision_flag, ev_mode_fault_flag, ev_ovr};

   // Control and status next value; hardware set wins over software clear
   always_comb begin
      cs_nxt = cs_r;
      if (wr_cs) begin
         // Flags keep only where software writes one; clears on zero
         cs_nxt[7:4] = cs_r[7:4] & reg_wdata[7:4];
         cs_nxt[`SPICSF_MODE_HI:`SPICSF_MODE_LO] =
            reg_wdata[`SPICSF_MODE_HI:`SPICSF_MODE_LO];
         cs_nxt[`SPICSF_EN_BIT] = reg_wdata[`SPICSF_EN_BIT];
      end
      if (ev_done) begin
         cs_nxt[`SPICSF_DONE_BIT] = 1'b1;
      end
      if (ev_write_collision_flag) begin
         cs_nxt[`SPICSF_WRITE_COLLISION_FLAG_BIT] = 1'b1;
      end
      if (ev_mode_fault_flag) begin
         cs_nxt[`SPICSF_MODE_FAULT_FLAG_BIT] = 1'b1;
      end
      if (ev_ovr) begin
         cs_nxt[`SPICSF_OVR_BIT] = 1'b1;
      end
      // Byte moving into shifter frees buffer; a new write wins
      if (tx_buf_to_shifter) begin
         cs_nxt[`SPICSF_TRANSMIT_BUFFER_EMPTY_BIT] = 1'b1;
      end
      if (data_ok) begin
         cs_nxt[`SPICSF_TRANSMIT_BUFFER_EMPTY_BIT] = 1'b0;
      end
   end

   // Event status: new events win over read clear
   assign evt_nxt = (rd_evt ? {`SPICSF_EV_W{1'b0}} : evt_r) | ev_vec;

   // Read data selection
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `SPICSF_CS_ADDR:   rdata_nxt = cs_r;
            `SPICSF_MASK_ADDR: rdata_nxt = {4'h0, mask_r};
            `SPICSF_EVT_ADDR:  rdata_nxt = {4'h0, evt_r};
            default:           rdata_nxt = 8'h00;
         endcase
      end
   end

   // Register file
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_r    <= `SPICSF_CS_RESET;
         evt_r   <= {`SPICSF_EV_W{1'b0}};
         mask_r  <= `SPICSF_MASK_RESET;
         rdata_r <= 8'h00;
         irq_r   <= 1'b0;
      end else begin
         cs_r    <= cs_nxt;
         evt_r   <= evt_nxt;
         mask_r  <= wr_mask ? reg_wdata[`SPICSF_EV_W-1:0] : mask_r;
         rdata_r <= rdata_nxt;
         irq_r   <= |(evt_r & mask_r);
      end
   end

   // Data hand-off to the shifter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_write_r <= 1'b0;
         tx_data_r  <= 8'h00;
      end else begin
         tx_write_r <= data_ok;
         tx_data_r  <= data_ok ? reg_wdata : tx_data_r;
      end
   end

   // Select line drive and input use by mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ss_out_r   <= 1'b1;
         ss_oe_r    <= 1'b0;
         ss_sel_r   <= 1'b0;
         sck_rise_r <= 1'b0;
      end else begin
         ss_oe_r    <= en_w && mode_single;
         ss_out_r   <= cs_r[`SPICSF_MODE_LO];
         ss_sel_r   <= en_w && (mode_four ? !nss_if.level : 1'b1);
         sck_rise_r <= en_w && sck_if.rise;
      end
   end

   assign reg_rdata             = rdata_r;
   assign irq                   = irq_r;
   assign tx_write              = tx_write_r;
   assign tx_data               = tx_data_r;
   assign port_enable           = en_w;
   assign slave_select_line_out = ss_out_r;
   assign slave_select_line_oe  = ss_oe_r;
   assign slave_selected        = ss_sel_r;
   assign sck_rise              = sck_rise_r;

   // Checks on the control logic
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   done_set_a: assert property (en_w && xfer_done |=> cs_r[7])
      else $error("Transfer done flag not set");
   write_collision_flag_set_a: assert property (wr_data && xfer_busy |=> cs_r[6] && !tx_write_r)
      else $error("Write collision not flagged");
   mode_fault_flag_set_a: assert property (en_w && master_mode_enable && mode_four && !nss_if.level
                                |=> cs_r[5])
      else $error("Mode fault not flagged");
   ovr_set_a: assert property (en_w && !master_mode_enable && last_bit_in && rx_buf_full
                               |=> cs_r[4])
      else $error("Receive overrun not flagged");
   err_irq_a: assert property ((ev_write_collision_flag || ev_mode_fault_flag || ev_ovr) && !rd_evt
                               && !wr_mask && (mask_r[2:0] == 3'h7)
                               ##1 !rd_evt |=> irq)
      else $error("Error event raised no interrupt");
   flag_hold_a: assert property (cs_r[6] && !wr_cs |=> cs_r[6])
      else $error("Error flag cleared without software");
   three_wire_a: assert property (mode_w == spicsf_pkg::SPICSF_THREE_WIRE
                                  |=> !slave_select_line_oe)
      else $error("Select pin driven in three wire mode");
   four_wire_a: assert property (mode_four |=> !slave_select_line_oe)
      else $error("Select pin driven in input mode");
   single_drv_a: assert property (en_w && mode_single |=> slave_select_line_oe
                                  && (slave_select_line_out == $past(cs_r[2])))
      else $error("Select output wrong in single master mode");
   transmit_buffer_empty_clr_a: assert property (data_ok |=> !cs_r[1] && tx_write_r)
      else $error("Transmit empty not cleared");
   transmit_buffer_empty_set_a: assert property (tx_buf_to_shifter && !data_ok |=> cs_r[1])
      else $error("Transmit empty not set");
   port_off_a: assert property (!en_w |=> !tx_write_r && !sck_rise_r)
      else $error("Disabled port active");

endmodule

// File: spicsf_peer_model.sv
// Far-side serial peer: drives the link clock and the select line
`timescale 1ns/1ps
module spicsf_peer_model;
   logic sck;       // Link clock, idle low outside frames
   logic sel_val;   // Select level while driven
   logic sel_oe;    // High while the peer drives select

   // Idle: link clock stands still, select released to the pull-up
   initial begin
      sck = 1'b0;
      sel_val = 1'b1;
      sel_oe = 1'b0;
   end

   // Drive select low or release it
   task automatic select(input logic on);
      sel_oe = on;
      sel_val = !on;
   endtask

   // One frame of n link clocks at 80 ns, then still again
   task automatic frame(input int n);
      for (int i = 0; i < n; i++) begin
         #40 sck = 1'b1;
         #40 sck = 1'b0;
      end
   endtask
endmodule

// File: spicsf_top_tb_top.sv
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`include "spicsf_map.svh"
module spicsf_top_tb_top;
   logic       clk, rst_n, reg_wr, reg_rd;            // Clock, reset, strobes
   logic [3:0] reg_addr;                              // Register address
   logic [7:0] reg_wdata, reg_rdata, tx_data;         // Bus data
   logic       irq, master_mode_enable, xfer_busy;    // Interrupt and core status
   logic       xfer_done, last_bit_in, rx_buf_full;   // Shifter events
   logic       tx_buf_to_shifter, tx_write;           // Transmit hand-off
   logic       port_enable, sel_out, sel_oe, sel_wire; // Select pin pieces
   logic       slave_selected, sck_rise;              // Link status
   int         err_total, samples_checked;            // Verdict counters
   int         tx_cnt, rise_cnt;                      // Pulse counters

   spicsf_peer_model u_peer ();

   // Select wire: device, then peer, else board pull-up
   assign sel_wire = sel_oe ? sel_out : (u_peer.sel_oe ? u_peer.sel_val : 1'b1);

   spicsf_top u_spicsf_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .master_mode_enable(master_mode_enable), .xfer_busy(xfer_busy),
      .xfer_done(xfer_done), .last_bit_in(last_bit_in), .rx_buf_full(rx_buf_full),
      .tx_buf_to_shifter(tx_buf_to_shifter), .tx_write(tx_write), .tx_data(tx_data),
      .port_enable(port_enable), .slave_select_line_in(sel_wire),
      .slave_select_line_out(sel_out), .slave_select_line_oe(sel_oe),
      .slave_selected(slave_selected), .sck_in(u_peer.sck), .sck_rise(sck_rise));

   // Clock at 250 MHz
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Count accepted data writes and link clock edges
   always @(posedge clk) begin
      if (tx_write === 1'b1) tx_cnt++;
      if (sck_rise === 1'b1) rise_cnt++;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read, then compare the data in the cycle after the strobe
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // One-cycle pulse on a shifter event: 0 done, 1 last bit, 2 to shifter
   task automatic pulse(input int which);
      @(posedge clk);
      xfer_done <= (which == 0);
      last_bit_in <= (which == 1);
      tx_buf_to_shifter <= (which == 2);
      @(posedge clk);
      {xfer_done, last_bit_in, tx_buf_to_shifter} <= 3'b000;
   endtask

   // Core status levels, changed just after a clock edge
   task automatic core(input logic mst, input logic full, input logic busy);
      @(posedge clk);
      master_mode_enable <= mst;
      rx_buf_full <= full;
      xfer_busy <= busy;
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog well beyond the expected run
   initial begin
      #60000;
      err_total++;
      close_out();
   end

   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {master_mode_enable, xfer_busy, xfer_done, last_bit_in} = '0;
      {rx_buf_full, tx_buf_to_shifter} = '0;
      {err_total, samples_checked, tx_cnt, rise_cnt} = '0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(`SPICSF_CS_ADDR, 8'h06);
      rdchk(`SPICSF_MASK_ADDR, 8'h00);
      rdchk(4'h4, 8'h00);
      wr(`SPICSF_DATA_ADDR, 8'hA5);
      cyc(2);
      chk(tx_cnt, 8'h00);
      wr(`SPICSF_CS_ADDR, 8'h05);
      rdchk(`SPICSF_CS_ADDR, 8'h07);
      chk(port_enable, 8'h01);
      wr(`SPICSF_DATA_ADDR, 8'h3C);
      rdchk(`SPICSF_CS_ADDR, 8'h05);
      chk(tx_data, 8'h3C);
      chk(tx_cnt, 8'h01);
      pulse(2);
      rdchk(`SPICSF_CS_ADDR, 8'h07);
      core(1'b0, 1'b0, 1'b1);
      wr(`SPICSF_DATA_ADDR, 8'hC3);
      core(1'b0, 1'b0, 1'b0);
      rdchk(`SPICSF_CS_ADDR, 8'h47);
      chk(tx_cnt, 8'h01);
      rdchk(`SPICSF_EVT_ADDR, 8'h04);
      cyc(20);
      wr(`SPICSF_CS_ADDR, 8'hF5);
      rdchk(`SPICSF_CS_ADDR, 8'h47);
      wr(`SPICSF_CS_ADDR, 8'h05);
      rdchk(`SPICSF_CS_ADDR, 8'h07);
      pulse(0);
      rdchk(`SPICSF_CS_ADDR, 8'h87);
      rdchk(`SPICSF_EVT_ADDR, 8'h08);
      wr(`SPICSF_CS_ADDR, 8'h05);
      core(1'b0, 1'b1, 1'b0);
      pulse(1);
      rdchk(`SPICSF_CS_ADDR, 8'h17);
      rdchk(`SPICSF_EVT_ADDR, 8'h01);
      wr(`SPICSF_CS_ADDR, 8'h05);
      core(1'b1, 1'b1, 1'b0);
      pulse(1);
      rdchk(`SPICSF_CS_ADDR, 8'h07);
      core(1'b1, 1'b0, 1'b0);
      u_peer.select(1'b1);
      cyc(12);
      rdchk(`SPICSF_CS_ADDR, 8'h27);
      wr(`SPICSF_CS_ADDR, 8'h01);
      cyc(4);
      // Fault still seen in the write cycle; the hardware set wins
      rdchk(`SPICSF_CS_ADDR, 8'h23);
      rdchk(`SPICSF_EVT_ADDR, 8'h02);
      u_peer.select(1'b0);
      core(1'b0, 1'b0, 1'b0);
      // Interrupt masked, then unmasked, then cleared by reading status
      pulse(0);
      cyc(3);
      chk(irq, 8'h00);
      wr(`SPICSF_MASK_ADDR, 8'h08);
      cyc(2);
      chk(irq, 8'h01);
      rdchk(`SPICSF_EVT_ADDR, 8'h08);
      cyc(2);
      chk(irq, 8'h00);
      // Error interrupts unmasked, then a write collision
      wr(`SPICSF_MASK_ADDR, 8'h07);
      core(1'b0, 1'b0, 1'b1);
      wr(`SPICSF_DATA_ADDR, 8'h5A);
      core(1'b0, 1'b0, 1'b0);
      cyc(2);
      chk(irq, 8'h01);
      rdchk(`SPICSF_EVT_ADDR, 8'h04);
      // Select pin modes
      wr(`SPICSF_CS_ADDR, 8'h09);
      cyc(2);
      chk({sel_oe, sel_out}, 8'h02);
      wr(`SPICSF_CS_ADDR, 8'h0D);
      cyc(2);
      chk({sel_oe, sel_out}, 8'h03);
      wr(`SPICSF_CS_ADDR, 8'h05);
      cyc(2);
      chk(sel_oe, 8'h00);
      u_peer.select(1'b1);
      cyc(10);
      chk(slave_selected, 8'h01);
      u_peer.select(1'b0);
      cyc(10);
      chk(slave_selected, 8'h00);
      wr(`SPICSF_CS_ADDR, 8'h01);
      cyc(4);
      chk({sel_oe, slave_selected}, 8'h01);
      // Link clock frame of eight edges
      u_peer.frame(8);
      cyc(10);
      chk(rise_cnt, 8'h08);
      wr(`SPICSF_CS_ADDR, 8'h00);
      u_peer.frame(4);
      cyc(10);
      chk(rise_cnt, 8'h08);
      close_out();
   end
endmodule
